// ===== src/sosc_pkg.sv
// Package: register map, field layout and timing constants for standby control
package sosc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_POWER_STATE = 8'h00;
    localparam logic [7:0] OFS_OUT_ENABLE = 8'h11;
    localparam logic [7:0] OFS_CORE_RESTART = 8'h14;
    localparam logic [7:0] OFS_LIGHT_VPOL = 8'h25;
    localparam logic [7:0] OFS_DEEP_VPOL = 8'h26;
    localparam logic [7:0] OFS_GPO_SPOL = 8'h27;
    localparam logic [7:0] OFS_GPO_EN = 8'h7A;
    localparam logic [7:0] OFS_MODE_CFG = 8'h80;
    localparam logic [7:0] OFS_STATUS = 8'h81;
    localparam int VPOL_W = 25;
    localparam int GPO_W = 24;
    localparam int HCLK_N = 8;
    localparam int VOUT_N = 24;
    localparam logic [1:0] PS_RESET = 2'h3;
    localparam logic [VPOL_W-1:0] VPOL_RESET = 25'h0000000;
    localparam logic [GPO_W-1:0] GPO_RESET = 24'h000000;
    localparam logic [3:0] HMODE_RESET = 4'h1;
    localparam int INHIBIT_PIX = 36;
    localparam int SLAVE_RST_DELAY = 2;
    localparam int SETTLE_US = 500;
    localparam int CLK_MHZ = 20;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    // Mode config bits
    localparam int CFG_SLAVE = 0;
    localparam int CFG_SYNC_POL = 1;
    localparam int CFG_HMODE_LSB = 4;
    typedef enum logic [4:0] {
        SOSC_RUN = 5'b00001,
        SOSC_LIGHT = 5'b00010,
        SOSC_MEDIUM = 5'b00100,
        SOSC_DEEP = 5'b01000,
        SOSC_OUTOFF = 5'b10000
    } sosc_ostate_e;
endpackage

// ===== src/sosc_standby_ctrl.sv
// Standby and output-state controller for the sensor timing generator
`timescale 1ns/100ps
module sosc_standby_ctrl
    import sosc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic vertical_sync_i,
    input wire logic horizontal_sync_i,
    input wire logic [HCLK_N-1:0] core_horizontal_clocks_i,
    input wire logic core_last_horizontal_i,
    input wire logic core_reset_gate_i,
    input wire logic core_vertical_sync_i,
    input wire logic core_horizontal_sync_i,
    input wire logic core_data_clock_i,
    input wire logic [VOUT_N-1:0] core_vertical_i,
    input wire logic core_substrate_i,
    input wire logic [GPO_W-1:0] core_general_i,
    output logic front_end_on_o,
    output logic references_on_o,
    output logic timing_core_on_o,
    output logic oscillator_on_o,
    output logic oscillator_out_gate_o,
    output logic timing_core_restart_o,
    output logic counter_reset_o,
    output logic [HCLK_N-1:0] horizontal_clocks_o,
    output logic [HCLK_N-1:0] horizontal_clocks_oe_b_o,
    output logic last_horizontal_clock_o,
    output logic reset_gate_clock_o,
    output logic hl_rg_oe_b_o,
    output logic weak_drive_o,
    output logic vertical_sync_o,
    output logic horizontal_sync_o,
    output logic data_output_clock_o,
    output logic data_outputs_zero_o,
    output logic [VOUT_N-1:0] vertical_clock_outs_o,
    output logic substrate_pulse_out_o,
    output logic [GPO_W-1:0] general_output_o,
    output logic [GPO_W-1:0] general_output_oe_b_o
);
    // Settle counter is 14 bits wide
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 16383) begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end

    // Write strobe decode for one register offset
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                    input logic [7:0] ofs);
        return wr && addr == ofs;
    endfunction

    logic [1:0] power_state_select_reg;
    logic out_enable_wr_reg;
    logic out_enable_reg;
    logic timing_core_restart_reg;
    logic [VPOL_W-1:0] light_vpol_reg;
    logic [VPOL_W-1:0] deep_vpol_reg;
    logic [GPO_W-1:0] gpo_spol_reg;
    logic [GPO_W-1:0] gpo_en_reg;
    logic [7:0] mode_cfg_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [2:0] vs_sync_reg;
    logic [2:0] hs_sync_reg;
    logic vs_level_reg;
    logic hs_level_reg;
    logic [1:0] slave_dly_reg;
    logic counter_reset_reg;
    logic [13:0] settle_cnt_reg;
    logic settle_pend_reg;
    sosc_ostate_e ostate;

    wire wr_ps = wr_hit(reg_wr_i, reg_addr_i, OFS_POWER_STATE);
    wire wr_oe = wr_hit(reg_wr_i, reg_addr_i, OFS_OUT_ENABLE);
    wire wr_rst = wr_hit(reg_wr_i, reg_addr_i, OFS_CORE_RESTART);
    wire wr_lvp = wr_hit(reg_wr_i, reg_addr_i, OFS_LIGHT_VPOL);
    wire wr_dvp = wr_hit(reg_wr_i, reg_addr_i, OFS_DEEP_VPOL);
    wire wr_gsp = wr_hit(reg_wr_i, reg_addr_i, OFS_GPO_SPOL);
    wire wr_gen = wr_hit(reg_wr_i, reg_addr_i, OFS_GPO_EN);
    wire wr_cfg = wr_hit(reg_wr_i, reg_addr_i, OFS_MODE_CFG);
    wire slave_mode = mode_cfg_reg[CFG_SLAVE];
    wire sync_pol = mode_cfg_reg[CFG_SYNC_POL];
    wire vs_agree = vs_sync_reg[2] == vs_sync_reg[1];
    wire hs_agree = hs_sync_reg[2] == hs_sync_reg[1];
    wire vs_fall = vs_agree && vs_level_reg && !vs_sync_reg[2];
    wire hs_fall = hs_agree && hs_level_reg && !hs_sync_reg[2];
    wire settle_block = settle_pend_reg && settle_cnt_reg != 14'h0000;

    // Output state, evaluated in priority order
    assign ostate = power_state_select_reg == 2'h3 ? SOSC_DEEP :
                    !out_enable_reg ? SOSC_OUTOFF :
                    power_state_select_reg == 2'h2 ? SOSC_MEDIUM :
                    power_state_select_reg == 2'h1 ? SOSC_LIGHT :
                    SOSC_RUN;

    // Power field, deep standby after reset
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_state_select_reg <= PS_RESET;
        end else if (wr_ps) begin
            power_state_select_reg <= reg_wdata_i[1:0];
        end
    end

    // Output enable as written, applied later at vertical sync
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_enable_wr_reg <= 1'b0;
        end else if (wr_oe) begin
            out_enable_wr_reg <= reg_wdata_i[0];
        end
    end

    // Timing core restart bit
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            timing_core_restart_reg <= 1'b0;
        end else if (wr_rst) begin
            timing_core_restart_reg <= reg_wdata_i[0];
        end
    end

    // Light and medium vertical polarities
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            light_vpol_reg <= VPOL_RESET;
        end else if (wr_lvp) begin
            light_vpol_reg <= reg_wdata_i[VPOL_W-1:0];
        end
    end

    // Deep standby vertical polarities
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            deep_vpol_reg <= VPOL_RESET;
        end else if (wr_dvp) begin
            deep_vpol_reg <= reg_wdata_i[VPOL_W-1:0];
        end
    end

    // General output standby polarities
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gpo_spol_reg <= GPO_RESET;
        end else if (wr_gsp) begin
            gpo_spol_reg <= reg_wdata_i[GPO_W-1:0];
        end
    end

    // General output enables
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gpo_en_reg <= GPO_RESET;
        end else if (wr_gen) begin
            gpo_en_reg <= reg_wdata_i[GPO_W-1:0];
        end
    end

    // Mode configuration
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_cfg_reg <= {HMODE_RESET, 4'h0};
        end else if (wr_cfg) begin
            mode_cfg_reg <= reg_wdata_i[7:0];
        end
    end

    // Sync pin filters and vertical-sync-updated output enable
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vs_sync_reg <= 3'h0;
            hs_sync_reg <= 3'h0;
            vs_level_reg <= 1'b0;
            hs_level_reg <= 1'b0;
            out_enable_reg <= 1'b0;
        end else begin
            vs_sync_reg <= {vs_sync_reg[1:0], vertical_sync_i};
            hs_sync_reg <= {hs_sync_reg[1:0], horizontal_sync_i};
            if (vs_agree) vs_level_reg <= vs_sync_reg[2];
            if (hs_agree) hs_level_reg <= hs_sync_reg[2];
            if (vs_fall) out_enable_reg <= out_enable_wr_reg;
        end
    end

    // Counter reset, slave mode only, delayed past the horizontal sync falling edge
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slave_dly_reg <= 2'h0;
            counter_reset_reg <= 1'b0;
        end else begin
            slave_dly_reg <= {slave_dly_reg[0], slave_mode && hs_fall};
            counter_reset_reg <= slave_mode ? slave_dly_reg[1] : 1'b0;
        end
    end

    // Oscillator settle timer after a write of run from medium or deep standby
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            settle_cnt_reg <= 14'h0000;
            settle_pend_reg <= 1'b0;
        end else if (wr_ps && reg_wdata_i[1:0] == 2'h0 &&
                     power_state_select_reg[1]) begin
            settle_cnt_reg <= 14'(SETTLE_CYCLES);
            settle_pend_reg <= 1'b1;
        end else if (settle_cnt_reg != 14'h0000) begin
            settle_cnt_reg <= settle_cnt_reg - 14'h0001;
        end else begin
            settle_pend_reg <= 1'b0;
        end
    end

    // Read port
    wire [DATA_W-1:0] status_word = {19'h0, settle_block, counter_reset_reg,
                                     out_enable_reg, 5'(ostate), 5'h0};
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_POWER_STATE: rdata_reg <= {30'h0, power_state_select_reg};
                OFS_OUT_ENABLE: rdata_reg <= {31'h0, out_enable_wr_reg};
                OFS_CORE_RESTART: rdata_reg <= {31'h0, timing_core_restart_reg};
                OFS_LIGHT_VPOL: rdata_reg <= {7'h0, light_vpol_reg};
                OFS_DEEP_VPOL: rdata_reg <= {7'h0, deep_vpol_reg};
                OFS_GPO_SPOL: rdata_reg <= {8'h0, gpo_spol_reg};
                OFS_GPO_EN: rdata_reg <= {8'h0, gpo_en_reg};
                OFS_MODE_CFG: rdata_reg <= {24'h0, mode_cfg_reg};
                OFS_STATUS: rdata_reg <= status_word;
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign reg_rdata_o = rdata_reg;

    // Power controls
    wire st_run = ostate == SOSC_RUN;
    wire st_light = ostate == SOSC_LIGHT;
    wire st_med = ostate == SOSC_MEDIUM;
    wire st_deep = ostate == SOSC_DEEP;
    wire st_off = ostate == SOSC_OUTOFF;
    wire ps_deep = power_state_select_reg == 2'h3;
    wire ps_med = power_state_select_reg == 2'h2;
    wire ps_light = power_state_select_reg == 2'h1;
    // Output-off leaves the core as the power field sets it
    wire core_off = ps_deep || ps_med;
    assign front_end_on_o = !core_off && !ps_light;
    assign references_on_o = !core_off;
    assign timing_core_on_o = !core_off;
    assign oscillator_on_o = !core_off;
    assign oscillator_out_gate_o = !core_off;
    // Restart held off until the oscillator has settled
    assign timing_core_restart_o = timing_core_restart_reg && !settle_block;
    assign counter_reset_o = counter_reset_reg;

    // Pin state selection
    wire [HCLK_N-1:0] h_idle = {(HCLK_N/2){2'b10}};
    wire h_parked = st_off || st_med || st_light;
    assign horizontal_clocks_o = st_deep ? '0 :
                                 h_parked ? h_idle : core_horizontal_clocks_i;
    assign horizontal_clocks_oe_b_o = {HCLK_N{st_deep}};
    assign last_horizontal_clock_o = st_run && core_last_horizontal_i;
    assign reset_gate_clock_o = st_run && core_reset_gate_i;
    assign hl_rg_oe_b_o = st_deep;
    assign weak_drive_o = st_med || st_light;
    wire sync_run = st_run || st_light;
    assign vertical_sync_o = st_deep ? 1'b0 :
                             sync_run ? core_vertical_sync_i : sync_pol;
    assign horizontal_sync_o = st_deep ? 1'b0 :
                               sync_run ? core_horizontal_sync_i : sync_pol;
    assign data_output_clock_o = (st_run || st_light || st_off) &&
                                 core_data_clock_i;
    assign data_outputs_zero_o = !st_run;
    // Vertical and substrate idle values come from the polarity registers
    wire [VPOL_W-1:0] vidle = st_deep ? deep_vpol_reg : light_vpol_reg;
    assign vertical_clock_outs_o = st_run ? core_vertical_i
                                          : vidle[VOUT_N-1:0];
    assign substrate_pulse_out_o = st_run ? core_substrate_i : vidle[VOUT_N];
    assign general_output_o = st_run ? core_general_i : gpo_spol_reg;
    assign general_output_oe_b_o = ~gpo_en_reg;
endmodule

// ===== bench/sosc_standby_ctrl_properties.sv
// Checker: power and output state properties on the controller ports
`timescale 1ns/100ps
module sosc_standby_ctrl_chk
    import sosc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic front_end_on_o,
    input wire logic references_on_o,
    input wire logic timing_core_on_o,
    input wire logic oscillator_on_o,
    input wire logic oscillator_out_gate_o,
    input wire logic timing_core_restart_o,
    input wire logic counter_reset_o,
    input wire logic [HCLK_N-1:0] horizontal_clocks_o,
    input wire logic [HCLK_N-1:0] horizontal_clocks_oe_b_o,
    input wire logic hl_rg_oe_b_o,
    input wire logic data_outputs_zero_o
);
    logic [1:0] ps_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Shadow of the power field
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) ps_q <= PS_RESET;
        else if (reg_wr_i && reg_addr_i == OFS_POWER_STATE)
            ps_q <= reg_wdata_i[1:0];
    end
    property p_deep_float;
        ps_q == 2'h3 |-> horizontal_clocks_oe_b_o == 8'hFF && hl_rg_oe_b_o;
    endproperty
    a_deep_float: assert property (p_deep_float) else $error("H not floated");
    property p_deep_off;
        ps_q == 2'h3 |-> !(front_end_on_o | timing_core_on_o | oscillator_on_o);
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep not off");
    property p_medium_off;
        ps_q == 2'h2 |-> !(timing_core_on_o | oscillator_out_gate_o);
    endproperty
    a_medium_off: assert property (p_medium_off) else $error("medium on");
    property p_light_on;
        ps_q == 2'h1 |-> references_on_o && timing_core_on_o && !front_end_on_o;
    endproperty
    a_light_on: assert property (p_light_on) else $error("light power");
    property p_run_on;
        ps_q == 2'h0 |-> front_end_on_o && oscillator_on_o;
    endproperty
    a_run_on: assert property (p_run_on) else $error("run power");
    property p_h_pattern;
        ps_q[0] ^ ps_q[1] |-> horizontal_clocks_o == 8'hAA
            && horizontal_clocks_oe_b_o == 8'h00;
    endproperty
    a_h_pattern: assert property (p_h_pattern) else $error("H pattern");
    property p_data_zero;
        ps_q != 2'h0 |-> data_outputs_zero_o;
    endproperty
    a_data_zero: assert property (p_data_zero) else $error("data not low");
    property p_settle;
        reg_wr_i && reg_addr_i == OFS_POWER_STATE && reg_wdata_i[1:0] == 2'h0
            && ps_q[1] |=> !timing_core_restart_o [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("restart early");
    property p_pulse;
        counter_reset_o |=> !counter_reset_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse long");
endmodule

// ===== bench/sosc_sensor_model.sv
// Far side model: sensor sync source, syncs idle high
`timescale 1ns/100ps
module sosc_sensor_model (
    input wire logic sys_clk_i,
    input wire logic fire_i,
    output logic vertical_sync_o,
    output logic horizontal_sync_o
);
    int left = 0;
    always @(posedge sys_clk_i) begin
        if (fire_i) left <= 6;
        else if (left > 0) left <= left - 1;
    end
    // HD falls with VD, never one cycle before it
    assign vertical_sync_o = !(left > 0);
    assign horizontal_sync_o = !(left > 0);
endmodule

// ===== bench/standby_output_state_control_tb_top.sv
// Testbench: registers, output states, restart and slave reset
`timescale 1ns/100ps
module standby_output_state_control_tb_top;
    import sosc_pkg::*;
    localparam int SETTLE = 20;
    logic sys_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, fire = 0;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o, rdv;
    logic vertical_sync_i, horizontal_sync_i, core_last_horizontal_i = 0;
    logic core_reset_gate_i = 0, core_vertical_sync_i = 0, core_substrate_i = 0;
    logic core_horizontal_sync_i = 0, core_data_clock_i = 0, weak_drive_o;
    logic [HCLK_N-1:0] core_horizontal_clocks_i = '0, horizontal_clocks_o;
    logic [VOUT_N-1:0] core_vertical_i = '0, vertical_clock_outs_o;
    logic [GPO_W-1:0] core_general_i = '0, general_output_o;
    logic [GPO_W-1:0] general_output_oe_b_o;
    logic [HCLK_N-1:0] horizontal_clocks_oe_b_o;
    logic front_end_on_o, references_on_o, timing_core_on_o, oscillator_on_o;
    logic oscillator_out_gate_o, timing_core_restart_o, counter_reset_o;
    logic last_horizontal_clock_o, reset_gate_clock_o, hl_rg_oe_b_o;
    logic vertical_sync_o, horizontal_sync_o, data_output_clock_o;
    logic data_outputs_zero_o, substrate_pulse_out_o;
    int seed = 29271, n_mismatch = 0, checks_done = 0, live = 0;
    int mdl[int] = '{0: 3, 'h11: 0, 'h14: 0, 'h25: 0, 'h26: 0, 'h27: 0, 'h7A: 0};
    int msk[int] = '{0: 3, 'h11: 1, 'h14: 1, 'h25: 'h1FFFFFF,
        'h26: 'h1FFFFFF, 'h27: 'hFFFFFF, 'h7A: 'hFFFFFF};
    sosc_standby_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (.*);
    sosc_sensor_model far (.sys_clk_i(sys_clk_i), .fire_i(fire),
        .vertical_sync_o(vertical_sync_i), .horizontal_sync_o(horizontal_sync_i));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        {core_horizontal_clocks_i, core_last_horizontal_i, core_reset_gate_i,
            core_vertical_sync_i, core_horizontal_sync_i, core_data_clock_i,
            core_vertical_i, core_substrate_i, core_general_i}
            <= 62'({$random(seed), $random(seed)});
    end
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input int a, input int d);
        reg_addr_i <= 8'(a);
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        if (mdl.exists(a)) mdl[a] = d & msk[a];
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input int a);
        reg_addr_i <= 8'(a);
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        rdv = reg_rdata_o;
        @(posedge sys_clk_i);
    endtask
    task automatic fire_sync();
        fire <= 1'b1;
        @(posedge sys_clk_i);
        fire <= 1'b0;
    endtask
    function automatic int st(int ps, int oe);
        if (ps == 3) return SOSC_DEEP;
        if (oe == 0) return SOSC_OUTOFF;
        return ps == 2 ? SOSC_MEDIUM : ps == 1 ? SOSC_LIGHT : SOSC_RUN;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        int ev;
        logic got;
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        foreach (mdl[a]) begin
            rd(a);
            chk("reset value", mdl[a], rdv);
        end
        rd('h55);
        chk("unmapped", 0, rdv);
        for (int a = 'h25; a < 'h28; a++) wr(a, $random(seed));
        wr('h7A, $random(seed));
        foreach (mdl[a]) begin
            rd(a);
            chk("readback", mdl[a], rdv);
        end
        $display("test registers done");
        for (int oe = 0; oe < 2; oe++) begin
            wr('h11, oe);
            rd('h81);
            chk("state before sync", st(mdl[0], live), rdv[9:5]);
            fire_sync();
            repeat (10) @(posedge sys_clk_i);
            live = oe;
            for (int ps = 3; ps >= 0; ps--) begin
                wr(0, ps);
                rd('h81);
                chk("state", st(ps, oe), rdv[9:5]);
                @(negedge sys_clk_i);
                ev = ps == 3 ? mdl['h26] : ps || !oe ? mdl['h25] : core_vertical_i;
                chk("vertical", ev & 'hFFFFFF, vertical_clock_outs_o);
                got = (ps == 3 || ps == 2 && oe) ? 1'b0 : core_data_clock_i;
                chk("weak, data_output_clock", {(ps == 1 || ps == 2) && oe, got},
                    {weak_drive_o, data_output_clock_o});
                if (ps == 3) chk("general", mdl['h27], general_output_o);
                chk("general oe", ~mdl['h7A] & 'hFFFFFF, general_output_oe_b_o);
                ev = ps == 3 ? mdl['h26] >> 24 : ps || !oe ? mdl['h25] >> 24
                    : core_substrate_i;
                chk("substrate", ev & 1, substrate_pulse_out_o);
                got = ps == 0 && oe;
                chk("hl rg", {got && core_last_horizontal_i,
                    got && core_reset_gate_i},
                    {last_horizontal_clock_o, reset_gate_clock_o});
                got = ps < 2 && oe;
                chk("syncs", {got && core_vertical_sync_i,
                    got && core_horizontal_sync_i},
                    {vertical_sync_o, horizontal_sync_o});
                @(posedge sys_clk_i);
            end
        end
        $display("test output states done");
        wr(0, 3);
        wr(0, 0);
        wr('h14, 0);
        wr('h14, 1);
        @(negedge sys_clk_i);
        chk("restart held", 0, timing_core_restart_o);
        repeat (SETTLE) @(negedge sys_clk_i);
        chk("restart out", 1, timing_core_restart_o);
        $display("test restart done");
        @(posedge sys_clk_i);
        wr('h80, 'h11);
        fire_sync();
        got = 0;
        for (int i = 0; i < 20 && !got; i++) begin
            @(negedge sys_clk_i);
            got = counter_reset_o === 1'b1;
        end
        chk("counter reset", 1, got);
        $display("test slave reset done");
        report_and_stop();
    end
endmodule
bind sosc_standby_ctrl sosc_standby_ctrl_chk u_chk (.*);
